// ===== mat_core.sv
`timescale 1ns/1ps
module mat_core
   import mat_pkg::*;
(
   input  wire logic                 mclk,
   input  wire logic                 arst_n,
   input  wire logic [2:0]           cpu_clock_divider_code,
   output logic                      cpu_clock_en,
   output logic                      mach_cycle_en,
   output logic                      exec_start,
   output logic [15:0]               start_pc,
   input  wire logic                 code_req,
   input  wire logic [15:0]          code_addr_in,
   output logic                      code_rd,
   output logic [15:0]               code_addr,
   input  wire logic [2:0]           vec_idx,
   output logic [15:0]               vec_addr,
   input  wire logic                 xd_req,
   input  wire logic                 xd_use_first_data_pointer,
   input  wire logic [7:0]           xd_ri,
   output logic                      xd_strobe,
   output logic [15:0]               xd_addr,
   output mat_pkg::mat_xsel_t        xd_sel,
   input  wire logic                 first_data_pointer_inc,
   input  wire logic                 first_data_pointer_load,
   input  wire logic [15:0]          first_data_pointer_ld_val,
   output logic [15:0]               first_data_pointer_value,
   input  wire mat_pkg::mat_id_req_t idr,
   output logic [7:0]                id_rdata,
   output logic                      id_bit_rdata,
   input  wire logic [2:0]           rn_idx,
   output logic [7:0]                rn_addr,
   input  wire logic                 timer0_gate_input,
   input  wire logic                 timer1_gate_input,
   output logic [1:0]                timer_ovf
);
   import mat_pkg::*;

   logic [DIV_W-1:0] div_cnt;
   logic [DIV_W-1:0] div_lim;
   logic [3:0]       mc_cnt;
   logic             boot_done;
   logic [15:0]      dptr0;
   logic [15:0]      second_data_pointer;
   logic [7:0]       data_pointer_select;
   logic [7:0]       page;
   logic [7:0]       program_status_word;
   logic [7:0]       timer_control_register;
   logic [7:0]       timer_mode_register;
   logic [7:0]       tl0;
   logic [7:0]       th0;
   logic [7:0]       tl1;
   logic [7:0]       th1;
   logic [1:0]       gsync1;
   logic [1:0]       gsync2;
   logic [1:0]       gsmp;
   logic [1:0]       gsmp_d;
   logic [7:0]       sfr_q;
   logic             rd_sfr;
   logic [2:0]       bit_q;
   logic [7:0]       ram_q;

   // clock divider: enable every BASE_DIV << code main clocks
   assign div_lim = DIV_W'(BASE_DIV) << cpu_clock_divider_code;
   assign cpu_clock_en = (div_cnt == div_lim - DIV_W'(1));
   assign mach_cycle_en = cpu_clock_en && (mc_cnt == 4'(MC_CLKS - 1));

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         div_cnt <= '0;
         mc_cnt  <= '0;
      end
      else
      begin
         // a code change mid-period restarts cleanly when the count passes
         div_cnt <= (div_cnt >= div_lim - DIV_W'(1)) ? '0 : div_cnt + DIV_W'(1);
         if (cpu_clock_en)
            mc_cnt <= mach_cycle_en ? 4'h0 : mc_cnt + 4'h1;
      end
   end

   // request decode
   logic       take_id;
   logic [7:0] bit_byte;
   logic [7:0] eff_addr;
   logic       to_sfr;
   logic [7:0] bit_mask;
   logic       sfr_wr;
   logic [7:0] sfr_rd;
   logic [7:0] wbyte;
   logic       sfr_hit;

   assign take_id  = cpu_clock_en && idr.req;
   assign bit_byte = idr.addr[7] ? {idr.addr[7:3], 3'h0}
                                 : (BIT_AREA | {4'h0, idr.addr[6:3]});
   assign eff_addr = idr.bit_op ? bit_byte : idr.addr;
   assign to_sfr   = eff_addr[7] && (idr.bit_op || !idr.indirect);
   assign bit_mask = 8'h01 << idr.addr[2:0];
   assign sfr_wr   = take_id && idr.wr && to_sfr;
   assign wbyte    = idr.bit_op ? ((sfr_rd & ~bit_mask) | ({8{idr.bit_val}} & bit_mask))
                                : idr.wdata;

   assign sfr_hit = (eff_addr == SFR_DPL0) || (eff_addr == SFR_DPH0)
                 || (eff_addr == SFR_DPL1) || (eff_addr == SFR_DPH1)
                 || ((eff_addr >= SFR_TIMER_CONTROL_REGISTER) && (eff_addr <= SFR_TH1))
                 || (eff_addr == SFR_DPS) || (eff_addr == SFR_PAGE)
                 || (eff_addr == SFR_PSW);
   // unimplemented reads return zero; writes there match no register
   assign sfr_rd = !sfr_hit              ? SFR_RST :
                   (eff_addr == SFR_DPL0) ? dptr0[7:0] :
                   (eff_addr == SFR_DPH0) ? dptr0[15:8] :
                   (eff_addr == SFR_DPL1) ? second_data_pointer[7:0] :
                   (eff_addr == SFR_DPH1) ? second_data_pointer[15:8] :
                   (eff_addr == SFR_TIMER_CONTROL_REGISTER) ? timer_control_register :
                   (eff_addr == SFR_TIMER_MODE_REGISTER) ? timer_mode_register :
                   (eff_addr == SFR_TL0)  ? tl0 :
                   (eff_addr == SFR_TL1)  ? tl1 :
                   (eff_addr == SFR_TH0)  ? th0 :
                   (eff_addr == SFR_TH1)  ? th1 :
                   (eff_addr == SFR_DPS)  ? data_pointer_select :
                   (eff_addr == SFR_PAGE) ? page : program_status_word;

   // internal RAM takes every non-register access, all 256 bytes
   mat_iram #(.WIDTH(8), .DEPTH(256), .AW(8)) u_iram (
      .mclk  (mclk),
      .en    (take_id && !to_sfr),
      .we    (idr.wr),
      .wmask (idr.bit_op ? bit_mask : 8'hFF),
      .wdata (idr.bit_op ? {8{idr.bit_val}} : idr.wdata),
      .addr  (eff_addr),
      .rdata (ram_q)
   );

   assign id_rdata     = rd_sfr ? sfr_q : ram_q;
   assign id_bit_rdata = id_rdata[bit_q];
   assign rn_addr      = {3'h0, program_status_word[PSW_RS0+1:PSW_RS0], rn_idx};

   // data pointers
   logic        sel1;
   logic [15:0] first_data_pointer_nxt;
   assign sel1       = data_pointer_select[DPS_SEL];
   assign first_data_pointer_value = sel1 ? second_data_pointer : dptr0;
   assign first_data_pointer_nxt   = first_data_pointer_load ? first_data_pointer_ld_val : first_data_pointer_value + 16'h0001;

   // timers
   logic [1:0] m0;
   logic [1:0] m1;
   logic       ev0;
   logic       ev1;
   logic [7:0] n_tl0;
   logic [7:0] n_th0;
   logic [7:0] n_tl1;
   logic [7:0] n_th1;
   logic       ov0_lo;
   logic       ov0_hi;
   logic       ov1_lo;

   assign m0  = timer_mode_register[1:0];
   assign m1  = timer_mode_register[TIMER_MODE_REGISTER_T1+1:TIMER_MODE_REGISTER_T1];
   // counter mode: high in one sample, low in the next
   assign ev0 = mach_cycle_en && (!timer_mode_register[TIMER_MODE_REGISTER_CT] || (gsmp_d[0] && !gsmp[0]));
   assign ev1 = mach_cycle_en && (!timer_mode_register[TIMER_MODE_REGISTER_T1+TIMER_MODE_REGISTER_CT] || (gsmp_d[1] && !gsmp[1]));

   mat_tmr u_tmr0 (
      .tl      (tl0),
      .th      (th0),
      .mode    (m0),
      .inc_lo  (timer_control_register[TIMER_CONTROL_REGISTER_TR0] && ev0),
      .inc_hi  (timer_control_register[TIMER_CONTROL_REGISTER_TR1] && mach_cycle_en),
      .next_tl (n_tl0),
      .next_th (n_th0),
      .ovf_lo  (ov0_lo),
      .ovf_hi  (ov0_hi)
   );

   mat_tmr u_tmr1 (
      .tl      (tl1),
      .th      (th1),
      .mode    (m1),
      .inc_lo  (timer_control_register[TIMER_CONTROL_REGISTER_TR1] && ev1 && (m1 != TM_MODE3)),
      .inc_hi  (1'b0),
      .next_tl (n_tl1),
      .next_th (n_th1),
      .ovf_lo  (ov1_lo),
      .ovf_hi  ()
   );

   logic       set_tf0;
   logic       set_tf1;
   logic [7:0] timer_control_register_w;
   assign set_tf0   = ov0_lo;
   assign set_tf1   = ov1_lo || ((m0 == TM_MODE3) && ov0_hi);
   assign timer_control_register_w    = (sfr_wr && eff_addr == SFR_TIMER_CONTROL_REGISTER) ? wbyte : timer_control_register;
   assign timer_ovf = {timer_control_register[TIMER_CONTROL_REGISTER_TF1], timer_control_register[TIMER_CONTROL_REGISTER_TF0]};

   // pin synchronisers, then one sample per machine cycle
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         gsync1 <= '0;
         gsync2 <= '0;
         gsmp   <= '0;
         gsmp_d <= '0;
      end
      else
      begin
         gsync1 <= {timer1_gate_input, timer0_gate_input};
         gsync2 <= gsync1;
         if (mach_cycle_en)
         begin
            gsmp   <= gsync2;
            gsmp_d <= gsmp;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         timer_control_register <= SFR_RST;
         timer_mode_register <= SFR_RST;
         tl0  <= SFR_RST;
         th0  <= SFR_RST;
         tl1  <= SFR_RST;
         th1  <= SFR_RST;
      end
      else
      begin
         // overflow flags: a set in the clearing cycle wins
         timer_control_register <= timer_control_register_w | {set_tf1, 1'b0, set_tf0, 5'h00};
         timer_mode_register <= (sfr_wr && eff_addr == SFR_TIMER_MODE_REGISTER) ? wbyte : timer_mode_register;
         // software writes override a count in the same cycle
         tl0  <= (sfr_wr && eff_addr == SFR_TL0) ? wbyte : n_tl0;
         th0  <= (sfr_wr && eff_addr == SFR_TH0) ? wbyte : n_th0;
         tl1  <= (sfr_wr && eff_addr == SFR_TL1) ? wbyte : n_tl1;
         th1  <= (sfr_wr && eff_addr == SFR_TH1) ? wbyte : n_th1;
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dptr0 <= '0;
         second_data_pointer <= '0;
         data_pointer_select   <= SFR_RST;
         page  <= SFR_RST;
         program_status_word   <= SFR_RST;
      end
      else
      begin
         if (sfr_wr && eff_addr == SFR_DPS)
            data_pointer_select <= wbyte;  // pointers untouched
         if (sfr_wr && eff_addr == SFR_PAGE)
            page <= wbyte;
         if (sfr_wr && eff_addr == SFR_PSW)
            program_status_word <= wbyte;
         if (sfr_wr && eff_addr == SFR_DPL0)
            dptr0[7:0] <= wbyte;
         if (sfr_wr && eff_addr == SFR_DPH0)
            dptr0[15:8] <= wbyte;
         if (sfr_wr && eff_addr == SFR_DPL1)
            second_data_pointer[7:0] <= wbyte;
         if (sfr_wr && eff_addr == SFR_DPH1)
            second_data_pointer[15:8] <= wbyte;
         // pointer instructions reach the selected pointer only
         if (cpu_clock_en && (first_data_pointer_inc || first_data_pointer_load))
         begin
            if (sel1)
               second_data_pointer <= first_data_pointer_nxt;
            else
               dptr0 <= first_data_pointer_nxt;
         end
      end
   end

   // external data address and decode
   logic [15:0] xa;
   assign xa = xd_use_first_data_pointer ? first_data_pointer_value : {page, xd_ri};

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         xd_strobe <= 1'b0;
         xd_addr   <= '0;
         xd_sel    <= '0;
         code_rd   <= 1'b0;
         code_addr <= RESET_PC;
         vec_addr  <= VEC_BASE;
         sfr_q     <= SFR_RST;
         rd_sfr    <= 1'b0;
         bit_q     <= '0;
      end
      else
      begin
         xd_strobe <= cpu_clock_en && xd_req;
         if (cpu_clock_en && xd_req)
         begin
            xd_addr           <= xa;
            xd_sel.shared_ram <= (xa >= SHARED_LO) && (xa <= SHARED_HI);
            xd_sel.ce_area    <= (xa >= SHARED_LO) && (xa <= CE_HI);
            xd_sel.cfg_ram    <= (xa >= CFG_LO) && (xa <= CFG_HI);
            xd_sel.bb_ram     <= (xa >= BB_LO) && (xa <= BB_HI);
            xd_sel.unmapped   <= !((xa <= SHARED_HI)
                                 || ((xa >= CFG_LO) && (xa <= BB_HI)));
         end
         code_rd <= cpu_clock_en && code_req;
         if (cpu_clock_en && code_req)
            code_addr <= code_addr_in;
         vec_addr <= VEC_BASE + (16'(vec_idx) << VEC_SHIFT);
         if (take_id)
         begin
            sfr_q  <= sfr_rd;
            rd_sfr <= to_sfr;
            bit_q  <= idr.addr[2:0];
         end
      end
   end

   // first cpu enable after reset launches execution at address zero
   assign start_pc = RESET_PC;
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         boot_done  <= 1'b0;
         exec_start <= 1'b0;
      end
      else
      begin
         exec_start <= cpu_clock_en && !boot_done;
         if (cpu_clock_en)
            boot_done <= 1'b1;
      end
   end

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   logic [3:0] hc;
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         hc <= '0;
      else if (cpu_clock_en)
         hc <= mach_cycle_en ? 4'h0 : hc + 4'h1;
   end

   sequence s_quiet3;
      // a code change in the gap stretches the period legally
      !cpu_clock_en [*3] ##1 (cpu_clock_en || cpu_clock_divider_code != 3'h0);
   endsequence
   property p_div0;
      cpu_clock_en && cpu_clock_divider_code == 3'h0 && $stable(cpu_clock_divider_code)
         |=> s_quiet3;
   endproperty
   a_div0: assert property (p_div0) else $error("div code 0 period not 4");

   property p_mc12;
      mach_cycle_en |-> cpu_clock_en && hc == 4'hB;
   endproperty
   a_mc12: assert property (p_mc12) else $error("machine cycle not 12 cpu clocks");

   property p_boot;
      exec_start |-> start_pc == 16'h0000 && !$past(boot_done);
   endproperty
   a_boot: assert property (p_boot) else $error("start not at zero");

   property p_vec;
      ##1 vec_addr == 16'h0003 + {10'h000, $past(vec_idx), 3'h0};
   endproperty
   a_vec: assert property (p_vec) else $error("vector spacing wrong");

   property p_xpage;
      cpu_clock_en && xd_req && !xd_use_first_data_pointer |=> xd_strobe && xd_addr == {$past(page), $past(xd_ri)};
   endproperty
   a_xpage: assert property (p_xpage) else $error("paged address wrong");

   property p_xdptr;
      cpu_clock_en && xd_req && xd_use_first_data_pointer |=> xd_addr == $past(first_data_pointer_value);
   endproperty
   a_xdptr: assert property (p_xdptr) else $error("pointer address wrong");

   property p_dps_keep;
      sfr_wr && eff_addr == SFR_DPS && !first_data_pointer_inc && !first_data_pointer_load |=> $stable(dptr0) && $stable(second_data_pointer);
   endproperty
   a_dps_keep: assert property (p_dps_keep) else $error("select changed pointer");

   property p_sel_only;
      cpu_clock_en && first_data_pointer_inc && !sfr_wr && data_pointer_select[0] |=> $stable(dptr0);
   endproperty
   a_sel_only: assert property (p_sel_only) else $error("unselected pointer moved");

   property p_indir;
      take_id && idr.indirect && !idr.bit_op && idr.addr[7] && idr.wr |=> $stable(program_status_word) && $stable(page);
   endproperty
   a_indir: assert property (p_indir) else $error("indirect write hit register");

   property p_stop;
      !timer_control_register[TIMER_CONTROL_REGISTER_TR0] && !sfr_wr && m0 != 2'h3 |=> $stable(tl0) && $stable(th0);
   endproperty
   a_stop: assert property (p_stop) else $error("timer 0 ran while stopped");

   property p_t1m3;
      m1 == 2'h3 && !sfr_wr |=> $stable(tl1) && $stable(th1);
   endproperty
   a_t1m3: assert property (p_t1m3) else $error("timer 1 ran in mode 3");
endmodule

// ===== mat_pkg.sv
package mat_pkg;
   // main_clock is the block clock; cpu_clock is an enable derived from it
   localparam int MAIN_CLK_HZ = 19_660_800;
   localparam int CPU_BASE_HZ = 4_915_200;
   localparam int BASE_DIV    = MAIN_CLK_HZ / CPU_BASE_HZ;
   localparam int DIV_W       = 10;
   localparam int MC_CLKS     = 12;

   localparam logic [15:0] RESET_PC  = 16'h0000;
   localparam logic [15:0] VEC_BASE  = 16'h0003;
   localparam int          VEC_SHIFT = 3;

   localparam logic [15:0] SHARED_LO = 16'h0000;
   localparam logic [15:0] SHARED_HI = 16'h0BFF;
   localparam logic [15:0] CE_HI     = 16'h03FF;
   localparam logic [15:0] CFG_LO    = 16'h2000;
   localparam logic [15:0] CFG_HI    = 16'h27FF;
   localparam logic [15:0] BB_LO     = 16'h2800;
   localparam logic [15:0] BB_HI     = 16'h287F;

   localparam logic [7:0] SFR_DPL0 = 8'h82;
   localparam logic [7:0] SFR_DPH0 = 8'h83;
   localparam logic [7:0] SFR_DPL1 = 8'h84;
   localparam logic [7:0] SFR_DPH1 = 8'h85;
   localparam logic [7:0] SFR_TIMER_CONTROL_REGISTER = 8'h88;
   localparam logic [7:0] SFR_TIMER_MODE_REGISTER = 8'h89;
   localparam logic [7:0] SFR_TL0  = 8'h8A;
   localparam logic [7:0] SFR_TL1  = 8'h8B;
   localparam logic [7:0] SFR_TH0  = 8'h8C;
   localparam logic [7:0] SFR_TH1  = 8'h8D;
   localparam logic [7:0] SFR_DPS  = 8'h92;
   localparam logic [7:0] SFR_PAGE = 8'hBF;
   localparam logic [7:0] SFR_PSW  = 8'hD0;
   localparam logic [7:0] SFR_RST  = 8'h00;
   localparam logic [7:0] BIT_AREA = 8'h20;

   localparam int TIMER_CONTROL_REGISTER_TF1 = 7;
   localparam int TIMER_CONTROL_REGISTER_TR1 = 6;
   localparam int TIMER_CONTROL_REGISTER_TF0 = 5;
   localparam int TIMER_CONTROL_REGISTER_TR0 = 4;
   localparam int TIMER_MODE_REGISTER_T1  = 4;
   localparam int TIMER_MODE_REGISTER_CT  = 2;
   localparam int PSW_RS0  = 3;
   localparam int DPS_SEL  = 0;
   localparam logic [1:0] TM_MODE3 = 2'h3;

   typedef struct packed {
      logic       req;
      logic       wr;
      logic       indirect;
      logic       bit_op;
      logic       bit_val;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mat_id_req_t;

   typedef struct packed {
      logic shared_ram;
      logic ce_area;
      logic cfg_ram;
      logic bb_ram;
      logic unmapped;
   } mat_xsel_t;
endpackage

// ===== mat_iram.sv
`timescale 1ns/1ps
module mat_iram #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 256,
   parameter int AW    = 8
) (
   input  wire logic             mclk,
   input  wire logic             en,
   input  wire logic             we,
   input  wire logic [WIDTH-1:0] wmask,
   input  wire logic [AW-1:0]    addr,
   input  wire logic [WIDTH-1:0] wdata,
   output logic      [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   // masked write lets single-bit stores skip a read-modify-write pass
   always_ff @(posedge mclk)
   begin
      if (en && we)
         mem[addr] <= (mem[addr] & ~wmask) | (wdata & wmask);
      if (en)
         rdata <= mem[addr];
   end
endmodule

// ===== mat_tmr.sv
`timescale 1ns/1ps
module mat_tmr (
   input  wire logic [7:0] tl,
   input  wire logic [7:0] th,
   input  wire logic [1:0] mode,
   input  wire logic       inc_lo,
   input  wire logic       inc_hi,
   output logic      [7:0] next_tl,
   output logic      [7:0] next_th,
   output logic            ovf_lo,
   output logic            ovf_hi
);
   logic [12:0] c13;
   logic [15:0] c16;
   logic [7:0]  lo8;
   logic [7:0]  hi8;

   assign c13 = {th, tl[4:0]} + 13'h0001;
   assign c16 = {th, tl} + 16'h0001;
   assign lo8 = tl + 8'h01;
   assign hi8 = th + 8'h01;

   always_comb
   begin
      next_tl = tl;
      next_th = th;
      ovf_lo  = 1'b0;
      ovf_hi  = 1'b0;
      unique case (mode)
         2'h0:
         begin
            if (inc_lo)
            begin
               next_tl = {3'h0, c13[4:0]};
               next_th = c13[12:5];
               ovf_lo  = &{th, tl[4:0]};
            end
         end
         2'h1:
         begin
            if (inc_lo)
            begin
               next_tl = c16[7:0];
               next_th = c16[15:8];
               ovf_lo  = &{th, tl};
            end
         end
         2'h2:
         begin
            if (inc_lo)
            begin
               next_tl = (&tl) ? th : lo8;
               ovf_lo  = &tl;
            end
         end
         2'h3:
         begin
            // split halves; the caller withholds both increments for timer 1
            if (inc_lo)
            begin
               next_tl = lo8;
               ovf_lo  = &tl;
            end
            if (inc_hi)
            begin
               next_th = hi8;
               ovf_hi  = &th;
            end
         end
      endcase
   end
endmodule

// ===== mat_evt_src.sv
`timescale 1ns/1ps
// event source on a timer gate pin; idles high, changes only on clock edges
module mat_evt_src (
   input  wire logic mclk,
   input  wire logic go,
   output logic      gate_out,
   output logic      done
);
   initial
   begin
      gate_out = 1'b1;
      done = 1'b0;
      wait (go === 1'b1);
      repeat (3)
      begin
         repeat (150) @(posedge mclk);
         gate_out <= 1'b0; // each level held about three machine cycles
         repeat (150) @(posedge mclk);
         gate_out <= 1'b1;
      end
      repeat (150) @(posedge mclk);
      done <= 1'b1;
   end
endmodule

// ===== tb_mat_core.sv
`timescale 1ns/1ps
module tb_mat_core;
   import mat_pkg::*;
   logic        mclk, arst_n, cpu_clock_en, mach_cycle_en, exec_start, code_req, code_rd;
   logic        xd_req, xd_use_first_data_pointer, xd_strobe, first_data_pointer_load, id_bit_rdata, gate1, go, ev_done;
   logic        first_data_pointer_inc;
   logic [2:0]  div_code, vec_idx, rn_idx;
   logic [7:0]  xd_ri, id_rdata, rn_addr;
   logic [1:0]  timer_ovf;
   logic [15:0] start_pc, code_addr_in, code_addr, vec_addr, xd_addr, first_data_pointer_ld_val, first_data_pointer_value;
   logic [15:0] rv;
   mat_xsel_t   xd_sel;
   mat_id_req_t idr;
   int          err_count = 0;
   int          n_checks = 0;
   int          mc_cnt = 0;
   int          snap, s0, n;

   mat_core dut_u (.mclk, .arst_n, .cpu_clock_divider_code(div_code), .cpu_clock_en,
      .mach_cycle_en, .exec_start, .start_pc, .code_req, .code_addr_in, .code_rd, .code_addr,
      .vec_idx, .vec_addr, .xd_req, .xd_use_first_data_pointer, .xd_ri, .xd_strobe, .xd_addr, .xd_sel,
      .first_data_pointer_inc, .first_data_pointer_load, .first_data_pointer_ld_val, .first_data_pointer_value, .idr, .id_rdata, .id_bit_rdata,
      .rn_idx, .rn_addr, .timer0_gate_input(1'b1), .timer1_gate_input(gate1), .timer_ovf);
   mat_evt_src evt_u (.mclk, .go, .gate_out(gate1), .done(ev_done));

   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   always @(posedge mclk) if (mach_cycle_en === 1'b1) mc_cnt <= mc_cnt + 1;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
   begin
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   end
   endtask

   task automatic report_and_stop;
   begin
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask

   // returns on the edge that takes a pending request
   task automatic take;
   begin
      do @(negedge mclk); while (cpu_clock_en !== 1'b1);
      snap = mc_cnt;
      @(posedge mclk);
   end
   endtask

   task automatic reg_op(input logic w, ind, bo, input logic [7:0] a, d);
   begin
      @(posedge mclk);
      idr <= '{1'b1, w, ind, bo, d[0], a, d};
      take();
      idr.req <= 1'b0;
      @(negedge mclk);
      rv = {8'h00, id_rdata};
   end
   endtask

   task automatic xd_op(input logic use_ptr, input logic [7:0] ri);
   begin
      @(posedge mclk);
      xd_req <= 1'b1;
      xd_use_first_data_pointer <= use_ptr;
      xd_ri <= ri;
      take();
      xd_req <= 1'b0;
      @(negedge mclk);
      check({15'h0, xd_strobe}, 16'h0001, "xd strobe");
   end
   endtask

   task automatic ptr_load(input logic inc, input logic [15:0] v);
   begin
      @(posedge mclk);
      first_data_pointer_load <= !inc;
      first_data_pointer_inc <= inc;
      first_data_pointer_ld_val <= v;
      take();
      first_data_pointer_load <= 1'b0;
      first_data_pointer_inc <= 1'b0;
   end
   endtask

   initial
   begin
      #300_000;
      err_count++;
      report_and_stop();
   end

   initial
   begin
      {arst_n, code_req, xd_req, xd_use_first_data_pointer, first_data_pointer_load, first_data_pointer_inc, go} = '0;
      {div_code, vec_idx, rn_idx, xd_ri, code_addr_in, first_data_pointer_ld_val} = '0;
      idr = '0;
      repeat (5) @(posedge mclk);
      arst_n <= 1'b1;
      @(negedge mclk);
      check(start_pc, 16'h0000, "start address");
      repeat (4) @(negedge mclk);
      check({15'h0, exec_start}, 16'h0001, "exec start");
      for (int c = 0; c < 8; c++)
      begin
         @(posedge mclk);
         div_code <= 3'(c);
         take();
         take();
         n = 0;
         do begin @(negedge mclk); n++; end while (cpu_clock_en !== 1'b1);
         check(16'(n), 16'(4 << c), "cpu clock period");
      end
      @(posedge mclk);
      div_code <= 3'h0;
      do @(negedge mclk); while (mach_cycle_en !== 1'b1);
      do @(negedge mclk); while (mach_cycle_en !== 1'b1);
      n = 0;
      do begin @(negedge mclk); n += (cpu_clock_en === 1'b1); end while (mach_cycle_en !== 1'b1);
      check(16'(n), 16'd12, "machine cycle");
      for (int i = 0; i < 8; i++)
      begin
         @(posedge mclk);
         vec_idx <= 3'(i);
         @(posedge mclk);
         @(negedge mclk);
         check(vec_addr, 16'h0003 + 16'(8 * i), "vector");
      end
      @(posedge mclk);
      code_req <= 1'b1;
      code_addr_in <= 16'hFFFF;
      take();
      code_req <= 1'b0;
      @(negedge mclk);
      check({15'h0, code_rd}, 16'h0001, "code read");
      check(code_addr, 16'hFFFF, "code address");
      $display("test clocks and code done");
      reg_op(1, 0, 0, SFR_PAGE, 8'h28);
      reg_op(1, 1, 0, SFR_PAGE, 8'h5A);
      reg_op(0, 0, 0, SFR_PAGE, 8'h00);
      check(rv, 16'h0028, "direct upper");
      reg_op(0, 1, 0, SFR_PAGE, 8'h00);
      check(rv, 16'h005A, "indirect upper");
      reg_op(1, 0, 0, 8'h81, 8'h77);
      reg_op(0, 0, 0, 8'h81, 8'h00);
      check(rv, 16'h0000, "unimplemented");
      xd_op(1'b0, 8'h10);
      check(xd_addr, 16'h2810, "paged address");
      check(16'(xd_sel), 16'h0002, "battery ram");
      reg_op(1, 0, 0, SFR_PAGE, 8'h03);
      xd_op(1'b0, 8'hFF);
      check(16'(xd_sel), 16'h0018, "engine area");
      reg_op(1, 0, 0, SFR_PAGE, 8'h30);
      xd_op(1'b0, 8'h00);
      check(16'(xd_sel), 16'h0001, "unmapped");
      ptr_load(1'b0, 16'h2000);
      reg_op(1, 0, 0, SFR_DPS, 8'h01);
      ptr_load(1'b0, 16'h0BFF);
      xd_op(1'b1, 8'h00);
      check(xd_addr, 16'h0BFF, "pointer address");
      check(16'(xd_sel), 16'h0010, "shared ram");
      ptr_load(1'b1, 16'h0000);
      @(negedge mclk);
      check(first_data_pointer_value, 16'h0C00, "pointer step");
      reg_op(1, 0, 0, SFR_DPS, 8'h00);
      check(first_data_pointer_value, 16'h2000, "first pointer kept");
      xd_op(1'b1, 8'h00);
      check(16'(xd_sel), 16'h0004, "config ram");
      reg_op(0, 0, 0, SFR_DPH1, 8'h00);
      check(rv, 16'h000C, "second pointer kept");
      reg_op(1, 0, 0, SFR_PSW, 8'h18);
      @(posedge mclk);
      rn_idx <= 3'h5;
      @(negedge mclk);
      check({8'h00, rn_addr}, 16'h001D, "bank");
      reg_op(1, 0, 0, 8'h21, 8'h81);
      reg_op(1, 0, 1, 8'h0B, 8'h01);
      reg_op(0, 0, 0, 8'h21, 8'h00);
      check(rv, 16'h0089, "bit area");
      reg_op(0, 0, 1, 8'h0B, 8'h00);
      check({15'h0, id_bit_rdata}, 16'h0001, "bit read");
      reg_op(1, 0, 1, 8'h8C, 8'h01);
      reg_op(0, 0, 0, SFR_TIMER_CONTROL_REGISTER, 8'h00);
      check(rv, 16'h0010, "register bit");
      $display("test addressing done");
      reg_op(1, 0, 0, SFR_TIMER_CONTROL_REGISTER, 8'h00);
      reg_op(1, 0, 0, SFR_TL0, 8'h00);
      reg_op(1, 0, 0, SFR_TIMER_MODE_REGISTER, 8'h51);
      reg_op(1, 0, 0, SFR_TIMER_CONTROL_REGISTER, 8'h50);
      // machine edges after the run bit lands, read back before the next take
      s0 = mc_cnt;
      go = 1'b1;
      wait (ev_done === 1'b1);
      reg_op(0, 0, 0, SFR_TL1, 8'h00);
      check(rv, 16'h0003, "event count");
      reg_op(0, 0, 0, SFR_TL0, 8'h00);
      check(rv, {8'h00, 8'(snap - s0)}, "timer count");
      reg_op(1, 0, 0, SFR_TIMER_CONTROL_REGISTER, 8'h00);
      reg_op(0, 0, 0, SFR_TL0, 8'h00);
      s0 = rv;
      repeat (200) @(posedge mclk);
      reg_op(0, 0, 0, SFR_TL0, 8'h00);
      check(rv, 16'(s0), "stopped timer");
      reg_op(1, 0, 0, SFR_TIMER_MODE_REGISTER, 8'h02);
      reg_op(1, 0, 0, SFR_TH0, 8'hF0);
      reg_op(1, 0, 0, SFR_TL0, 8'hFE);
      reg_op(1, 0, 0, SFR_TIMER_CONTROL_REGISTER, 8'h10);
      s0 = mc_cnt;
      repeat (240) @(posedge mclk);
      reg_op(0, 0, 0, SFR_TL0, 8'h00);
      n = snap - s0;
      check(rv, 16'(n < 2 ? 8'hFE + n : 8'hF0 + n - 2), "reload");
      check({14'h0, timer_ovf}, 16'h0001, "overflow flag");
      $display("test timers done");
      report_and_stop();
   end
endmodule
